// File: hdl/dms_mult_stage.sv
/*
  Multiplier stage: operand input registers with shift chain,
  sign control, 9/18/36-bit products, 18-bit fractional rounding and
  saturation, optional pipeline register, APB register file
  and a level interrupt. Assumes all inputs are synchronous
  to clk; fabric keeps the operand conventions below.
*/
`timescale 1ns/100ps
module dms_mult_stage
  import dms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  ena,
  input  wire logic [3:0]  aclr,
  input  wire logic [35:0] data_a,
  input  wire logic [35:0] data_b,
  input  wire logic [35:0] shiftin_a,
  input  wire logic [35:0] shiftin_b,
  input  wire logic        sign_a,
  input  wire logic        sign_b,
  input  wire logic        source_a,
  input  wire logic        source_b,
  output logic      [35:0] shiftout_a,
  output logic      [35:0] shiftout_b,
  output logic      [71:0] product,
  output logic             product_sat_flag,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  // Register file and datapath state
  logic [14:0] ctrl;        // Configuration
  logic [1:0]  stat;        // Sticky events
  logic [1:0]  mask;        // Interrupt mask
  logic [35:0] a_reg;       // Operand A register
  logic [35:0] b_reg;       // Operand B register
  logic        sa_q;        // Registered controls
  logic        sb_q;
  logic        srca_q;
  logic        srcb_q;
  logic [71:0] pipe_q;      // Pipeline register
  logic        pflag_q;
  logic        sat_q;       // Saturation seen, piped
  logic        sat_pq;
  logic        src_err;     // Shift request in 36 mode
  dms_mode_t   mode;
  logic        wr_acc;
  logic        rd_acc;
  logic        map_ok;
  logic [31:0] next_rdata;
  logic [1:0]  ev;

  // Size from the control word; code 3 is left unused
  assign mode = dms_mode_t'(ctrl[DMS_MODE_LSB +: 2]);

  // Per-register enable and clear picked by selects
  // The four enables stand in for four separate clocks
  logic ena_a, ena_b, ena_p, clr_a, clr_b, clr_p;
  always_comb begin
    ena_a = ena[ctrl[DMS_ASEL_LSB +: 2]];
    clr_a = aclr[ctrl[DMS_ASEL_LSB +: 2]];
    ena_b = ena[ctrl[DMS_BSEL_LSB +: 2]];
    clr_b = aclr[ctrl[DMS_BSEL_LSB +: 2]];
    ena_p = ena[ctrl[DMS_PSEL_LSB +: 2]];
    clr_p = aclr[ctrl[DMS_PSEL_LSB +: 2]];
  end

  // Controls follow the A register when registered
  // Cleared with A so a stale sign never meets new data
  always_ff @(posedge clk) begin
    if (!rst_n || clr_a) begin
      sa_q   <= 1'b0;
      sb_q   <= 1'b0;
      srca_q <= 1'b0;
      srcb_q <= 1'b0;
    end else if (ena_a) begin
      sa_q   <= sign_a;
      sb_q   <= sign_b;
      srca_q <= source_a;
      srcb_q <= source_b;
    end
  end

  // Effective controls; sign gate off means unsigned
  logic sa_e, sb_e, srca_e, srcb_e;
  always_comb begin
    sa_e   = ctrl[DMS_CREG_BIT] ? sa_q : sign_a;
    sb_e   = ctrl[DMS_CREG_BIT] ? sb_q : sign_b;
    sa_e   = sa_e & ctrl[DMS_SGNU_BIT];
    sb_e   = sb_e & ctrl[DMS_SGNU_BIT];
    srca_e = ctrl[DMS_CREG_BIT] ? srca_q : source_a;
    srcb_e = ctrl[DMS_CREG_BIT] ? srcb_q : source_b;
  end

  // Source choice; 36x36 has no chain path
  logic [35:0] a_in, b_in;
  always_comb begin
    a_in = data_a;
    b_in = data_b;
    if (srca_e && mode != DMS_M36) begin
      a_in = shiftin_a;
    end
    if (srcb_e && mode != DMS_M36) begin
      b_in = shiftin_b;
    end
    src_err = (srca_e | srcb_e) && mode == DMS_M36;
  end

  // Operand input registers, chain taps
  always_ff @(posedge clk) begin
    if (!rst_n || clr_a) begin
      a_reg <= 36'h0_0000_0000;
    end else if (ena_a) begin
      a_reg <= a_in;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || clr_b) begin
      b_reg <= 36'h0_0000_0000;
    end else if (ena_b) begin
      b_reg <= b_in;
    end
  end
  assign shiftout_a = a_reg;
  assign shiftout_b = b_reg;

  // Width-dependent sign extension to 37 bits
  // Only bits 17:0 of the 36-bit bus reach the multiplier in 18 mode
  function automatic logic [36:0] ext(
    input logic [35:0] v,
    input logic        s,
    input dms_mode_t   m
  );
    logic [36:0] r;
    r = {1'b0, v};
    case (m)
      DMS_M9:  r = {{28{s & v[8]}}, v[8:0]};
      DMS_M18: r = {{19{s & v[17]}}, v[17:0]};
      default: r = {s & v[35], v};
    endcase
    return r;
  endfunction

  // Full-precision signed-by-extension multiply
  logic [36:0] ea, eb;
  logic [73:0] mul;
  logic [71:0] raw;
  always_comb begin
    ea  = ext(ctrl[DMS_AREG_BIT] ? a_reg : a_in, sa_e, mode);
    eb  = ext(ctrl[DMS_BREG_BIT] ? b_reg : b_in, sb_e, mode);
    // Operands widened to the product width; no bit is lost
    mul = $signed({{37{ea[36]}}, ea}) *
          $signed({{37{eb[36]}}, eb});
    raw = mul[71:0];
  end

  // Fractional path: round, then overflow check
  // Saturation looks at the rounded value, so a carry out of
  // rounding cannot slip past the largest fraction unflagged
  logic        frac;
  logic [35:0] p36, rnd, fr;
  logic        sat;
  logic [71:0] res;
  logic        rflag;
  always_comb begin
    frac = mode == DMS_M18 &&
           (ctrl[DMS_SAT_BIT] | ctrl[DMS_RND_BIT]);
    p36  = raw[35:0];
    rnd  = p36;
    if (ctrl[DMS_RND_BIT]) begin
      rnd = (p36 + DMS_RND_ADD) & DMS_RND_MSK;
    end
    // Only -1 x -1, or a rounding carry on a product just below it, can make the two sign bits differ
    sat  = ctrl[DMS_SAT_BIT] && (rnd[35] ^ rnd[34]);
    fr   = sat ? DMS_SAT_VAL : rnd;
    // Bits 2..0 are zero here as inputs have zero LSBs
    res  = frac ? {{36{fr[35]}}, fr} : raw;
    rflag = ctrl[DMS_SAT_BIT] && frac ? sat : res[0];
  end

  // Optional pipeline register
  // Pipe select picks its own enable and clear pair
  always_ff @(posedge clk) begin
    if (!rst_n || clr_p) begin
      pipe_q  <= 72'h00_0000_0000_0000_0000;
      pflag_q <= 1'b0;
      sat_pq  <= 1'b0;
    end else if (ena_p) begin
      pipe_q  <= res;
      pflag_q <= rflag;
      sat_pq  <= sat & frac;
    end
  end

  // Output flop; bypass costs no cycle beyond it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      product          <= 72'h00_0000_0000_0000_0000;
      product_sat_flag <= 1'b0;
      sat_q            <= 1'b0;
    end else if (ctrl[DMS_PIPE_BIT]) begin
      product          <= pipe_q;
      product_sat_flag <= pflag_q;
      sat_q            <= sat_pq;
    end else begin
      product          <= res;
      product_sat_flag <= rflag;
      sat_q            <= sat & frac;
    end
  end

  // APB decode; one wait state per access
  assign map_ok = paddr == DMS_CTRL_OFF || paddr == DMS_STAT_OFF ||
                  paddr == DMS_MASK_OFF || paddr == DMS_PRLO_OFF ||
                  paddr == DMS_PRHI_OFF;
  // Writes land on the edge that completes the transfer
  assign wr_acc = psel && penable && pready && pwrite && map_ok;
  assign rd_acc = psel && penable && !pready;

  // Read mux; unused bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      DMS_CTRL_OFF: next_rdata = {17'h0_0000, ctrl};
      DMS_STAT_OFF: next_rdata = {30'h0000_0000, stat};
      DMS_MASK_OFF: next_rdata = {30'h0000_0000, mask};
      DMS_PRLO_OFF: next_rdata = product[31:0];
      DMS_PRHI_OFF: next_rdata = product[63:32];
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus handshake
  // pready stands one cycle, giving one wait state per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= rd_acc && !map_ok;
      if (rd_acc && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // Configuration writes
  // Refused addresses fail map_ok and change nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= DMS_CTRL_RST;
      mask <= DMS_MASK_RST;
    end else if (wr_acc) begin
      if (paddr == DMS_CTRL_OFF) begin
        ctrl <= pwdata[14:0];
      end
      if (paddr == DMS_MASK_OFF) begin
        mask <= pwdata[1:0];
      end
    end
  end

  // Sticky events; a new event beats the clear
  assign ev = {src_err, sat_q};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat <= 2'h0;
    end else begin
      if (wr_acc && paddr == DMS_STAT_OFF) begin
        stat <= (stat & ~pwdata[1:0]) | ev;
      end else begin
        stat <= stat | ev;
      end
    end
  end

  // Level interrupt
  // Registered so irq leaves a flop; costs one cycle of lag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  // Checks
  // past_ok keeps $past terms clear of reset history
  logic past_ok;
  always_ff @(posedge clk) begin
    past_ok <= rst_n;
  end

  a_chain_tap: assert property (@(posedge clk) disable iff (!rst_n)
    past_ok && $past(ena_a) && !$past(clr_a) |->
      shiftout_a == $past(a_in))
    else $error("shift output A not loaded");
  a_no_chain36: assert property (@(posedge clk) disable iff (!rst_n)
    mode == DMS_M36 |-> a_in == data_a && b_in == data_b)
    else $error("shift input used in 36 mode");
  a_src_pick: assert property (@(posedge clk) disable iff (!rst_n)
    srca_e && mode != DMS_M36 |-> a_in == shiftin_a)
    else $error("source select ignored");
  a_unsigned_def: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl[DMS_SGNU_BIT] |-> !sa_e && !sb_e)
    else $error("sign used while gated off");
  a_prod_exact: assert property (@(posedge clk) disable iff (!rst_n)
    !frac |-> $signed(raw) == $signed(ea) * $signed(eb))
    else $error("product not full precision");
  a_sat_value: assert property (@(posedge clk) disable iff (!rst_n)
    sat && frac |-> res[35:0] == DMS_SAT_VAL)
    else $error("saturated value wrong");
  a_rnd_low: assert property (@(posedge clk) disable iff (!rst_n)
    frac && ctrl[DMS_RND_BIT] |-> res[15:0] == 16'h0000)
    else $error("rounded low bits not zero");
  a_frac_mode: assert property (@(posedge clk) disable iff (!rst_n)
    mode != DMS_M18 |-> res == raw)
    else $error("fraction option outside 18 mode");
  a_flag_out: assert property (@(posedge clk) disable iff (!rst_n)
    past_ok && !$past(ctrl[DMS_PIPE_BIT]) |->
      product_sat_flag == $past(rflag))
    else $error("flag not from product");
  a_pipe_delay: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl[DMS_PIPE_BIT] && ena_p && !clr_p ##1
      ctrl[DMS_PIPE_BIT] |=> product == $past(res, 2))
    else $error("pipeline delay wrong");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    |(stat & mask) |=> irq)
    else $error("interrupt missed");
  a_sat_flag: assert property (@(posedge clk) disable iff (!rst_n)
    sat && frac && !ctrl[DMS_PIPE_BIT] |=> product_sat_flag)
    else $error("saturation flag not raised");
  a_stat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    ev[DMS_EV_SRC] |=> stat[DMS_EV_SRC])
    else $error("source event lost to a clear");

  c_sat_hit: cover property (@(posedge clk) disable iff (!rst_n)
    sat && frac);
  c_chain: cover property (@(posedge clk) disable iff (!rst_n)
    srca_e && ena_a && mode == DMS_M18);
  c_m36: cover property (@(posedge clk) disable iff (!rst_n)
    mode == DMS_M36 && sa_e && sb_e);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
  c_round: cover property (@(posedge clk) disable iff (!rst_n)
    frac && ctrl[DMS_RND_BIT]);
endmodule // dms_mult_stage

// File: hdl/dms_pkg.sv
/*
  Constants of the multiplier stage: register map, control
  field positions, reset values and fractional-mode figures.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package dms_pkg;
  // Register byte offsets
  localparam logic [7:0] DMS_CTRL_OFF = 8'h00;
  localparam logic [7:0] DMS_STAT_OFF = 8'h04;
  localparam logic [7:0] DMS_MASK_OFF = 8'h08;
  localparam logic [7:0] DMS_PRLO_OFF = 8'h0C;
  localparam logic [7:0] DMS_PRHI_OFF = 8'h10;
  // Control field positions
  localparam int DMS_AREG_BIT = 0;
  localparam int DMS_BREG_BIT = 1;
  localparam int DMS_ASEL_LSB = 2;
  localparam int DMS_BSEL_LSB = 4;
  localparam int DMS_PIPE_BIT = 6;
  localparam int DMS_PSEL_LSB = 7;
  localparam int DMS_CREG_BIT = 9;
  localparam int DMS_MODE_LSB = 10;
  localparam int DMS_SAT_BIT  = 12;
  localparam int DMS_RND_BIT  = 13;
  localparam int DMS_SGNU_BIT = 14;
  localparam int DMS_CTRL_W   = 15;
  // Status bit positions
  localparam int DMS_EV_SAT   = 0;
  localparam int DMS_EV_SRC   = 1;
  localparam int DMS_EV_W     = 2;
  // Reset values
  localparam logic [14:0] DMS_CTRL_RST = 15'h0000;
  localparam logic [1:0]  DMS_MASK_RST = 2'h0;
  // Multiplier sizes
  typedef enum logic [1:0] {
    DMS_M9  = 2'h0,
    DMS_M18 = 2'h1,
    DMS_M36 = 2'h2
  } dms_mode_t;
  // Fractional figures on the 36-bit product
  localparam logic [35:0] DMS_RND_ADD = 36'h0_0004_0000;
  localparam logic [35:0] DMS_RND_MSK = 36'hF_FFFF_0000;
  localparam logic [35:0] DMS_SAT_VAL = 36'h3_FFFF_FFF8;
endpackage

// File: sim/dms_chain_src.sv
/* Model of the stage above: its operand registers feed our
   shift inputs. Assumes the bench loads it before use. */
`timescale 1ns/100ps
module dms_chain_src (
  input  wire logic        clk,
  input  wire logic        load,
  input  wire logic [35:0] val_a,
  input  wire logic [35:0] val_b,
  output logic      [35:0] shiftin_a,
  output logic      [35:0] shiftin_b
);
  // Registered like a real input stage, so it holds between loads
  always_ff @(posedge clk) begin
    if (load) begin
      shiftin_a <= val_a;
      shiftin_b <= val_b;
    end
  end
endmodule // dms_chain_src

// File: sim/dms_mult_stage_test.sv
/* Self-checking bench of the multiplier stage: APB master,
   operand stimulus and a chain source model. Assumes one clk. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dms_mult_stage_test import dms_pkg::*; ;
  localparam logic [31:0] SG = 1 << DMS_SGNU_BIT;
  localparam logic [31:0] M18 = 1 << DMS_MODE_LSB;
  localparam logic [31:0] M36 = 2 << DMS_MODE_LSB;
  localparam logic [31:0] ST = 1 << DMS_SAT_BIT;
  localparam logic [31:0] RN = 1 << DMS_RND_BIT;
  localparam logic [31:0] PP = 1 << DMS_PIPE_BIT;
  localparam logic [31:0] AR = 1 << DMS_AREG_BIT;
  // Stimulus, all driven on the rising edge
  logic        clk = 0, rst_n = 0, ld = 0, psel = 0, penable = 0;
  logic        pwrite = 0, sign_a = 0, sign_b = 0;
  logic        source_a = 0, source_b = 0;
  logic [3:0]  ena = 4'hF, aclr = 4'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [35:0] data_a = '0, data_b = '0, ld_a = '0, ld_b = '0;
  // Observed outputs
  logic [35:0] shin_a, shin_b, shout_a, shout_b;
  logic [71:0] product;
  logic [31:0] prdata, rd;
  logic        sflag, pready, pslverr, irq, er;
  int          bad_count = 0, num_checks = 0, cyc = 0;

  dms_chain_src src_u (.clk(clk), .load(ld), .val_a(ld_a),
    .val_b(ld_b), .shiftin_a(shin_a), .shiftin_b(shin_b));
  dms_mult_stage dut_u (.clk(clk), .rst_n(rst_n), .ena(ena),
    .aclr(aclr), .data_a(data_a), .data_b(data_b),
    .shiftin_a(shin_a), .shiftin_b(shin_b), .sign_a(sign_a),
    .sign_b(sign_b), .source_a(source_a), .source_b(source_b),
    .shiftout_a(shout_a), .shiftout_b(shout_b), .product(product),
    .product_sat_flag(sflag), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  always #4 clk = ~clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // Operand extended to 72 bits by its own sign
  function automatic logic [71:0] xt(logic [35:0] v, logic s, int w);
    logic [71:0] m;
    m = (72'h1 << w) - 1;
    return (s && v[w-1]) ? ({36'h0, v} | ~m) : ({36'h0, v} & m);
  endfunction

  // One APB transfer; the request holds until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Present operands, then wait the stated latency
  task automatic drv(input logic [35:0] a, b, input logic sa, sb,
                     input int lat);
    @(posedge clk);
    data_a <= a; data_b <= b; sign_a <= sa; sign_b <= sb;
    repeat (lat) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    apb(0, DMS_CTRL_OFF, 0);
    `CHK("ctrl reset", 32'(DMS_CTRL_RST), rd)
    apb(0, DMS_MASK_OFF, 0);
    `CHK("mask reset", 32'(DMS_MASK_RST), rd)
    apb(0, 8'h14, 0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1, DMS_CTRL_OFF, SG | M36);
    apb(0, DMS_CTRL_OFF, 0);
    `CHK("ctrl rw", SG | M36, rd)
    $display("test regs done");
  endtask

  // Every sign mix in every size, with sign inputs used or not
  task automatic t_sign;
    logic [71:0] ex, mk;
    int w;
    for (int m = 0; m < 3; m++) begin
      for (int u = 0; u < 2; u++) begin
        apb(1, DMS_CTRL_OFF, 32'((m << DMS_MODE_LSB) | (u << 14)));
        w = (m == 0) ? 9 : (m == 1) ? 18 : 36;
        mk = (m == 2) ? '1 : (72'h1 << (2 * w)) - 1;
        for (int s = 0; s < 4; s++) begin
          drv(36'hF_FFFF_FFFD, 36'h8_0002_0185, s[1], s[0], 1);
          ex = xt(36'hF_FFFF_FFFD, s[1] & u[0], w) *
               xt(36'h8_0002_0185, s[0] & u[0], w);
          `CHK("product", ex & mk, product & mk)
        end
      end
    end
    $display("test sign done");
  endtask

  // Fractions sit in bits 17:2, both operands signed
  task automatic t_frac;
    apb(1, DMS_CTRL_OFF, SG | M18 | ST);
    drv(36'h2_0000, 36'h2_0000, 1, 1, 1);
    `CHK("sat value", {36'h0, DMS_SAT_VAL}, product)
    `CHK("sat flag", 1'b1, sflag)
    drv(36'h1_0000, 36'h1_0000, 1, 1, 1);
    `CHK("no sat", 72'h1_0000_0000, product)
    `CHK("flag low", 1'b0, sflag)
    apb(0, DMS_STAT_OFF, 0);
    `CHK("stat sat", 1'b1, rd[DMS_EV_SAT])
    `CHK("irq masked", 1'b0, irq)
    apb(1, DMS_MASK_OFF, 1);
    @(posedge clk);
    #1 `CHK("irq set", 1'b1, irq)
    apb(1, DMS_STAT_OFF, 1);
    @(posedge clk);
    #1 `CHK("irq clear", 1'b0, irq)
    apb(1, DMS_CTRL_OFF, SG | M18 | RN);
    drv(36'hC, 36'h1_0004, 1, 1, 1);
    `CHK("round", 72'h10_0000, product)
    apb(1, DMS_CTRL_OFF, SG | M18);
    drv(36'h3, 36'h5, 1, 1, 1);
    `CHK("flag mirror", 1'b1, sflag)
    apb(1, DMS_CTRL_OFF, SG | ST);
    drv(36'h100, 36'h100, 1, 1, 1);
    `CHK("no sat in 9", 18'h1_0000, product[17:0])
    $display("test frac done");
  endtask

  // Input register fed from the chain, then parallel, hold, clear
  task automatic t_shift;
    apb(1, DMS_CTRL_OFF, M18 | AR);
    @(posedge clk);
    ld <= 1; ld_a <= 36'h123; ld_b <= 36'h456;
    @(posedge clk);
    ld <= 0; source_a <= 1; source_b <= 1;
    drv(36'h7, 36'h5, 0, 0, 2);
    `CHK("chain out", 36'h123, shout_a)
    `CHK("chain out b", 36'h456, shout_b)
    `CHK("chain prod", 72'h4_EDC2, product)
    @(posedge clk);
    source_a <= 0; source_b <= 0;
    drv(36'h7, 36'h5, 0, 0, 2);
    `CHK("parallel", 36'h7, shout_a)
    `CHK("parallel b", 36'h5, shout_b)
    @(posedge clk);
    ena <= 4'hE;
    drv(36'h9, 36'h5, 0, 0, 2);
    `CHK("ena hold", 36'h7, shout_a)
    @(posedge clk);
    ena <= 4'hF; aclr <= 4'h1;
    drv(36'h9, 36'h5, 0, 0, 2);
    `CHK("clear", 36'h0, shout_a)
    @(posedge clk);
    aclr <= 4'h0; source_a <= 1;
    apb(1, DMS_CTRL_OFF, M36);
    drv(36'h3, 36'h5, 0, 0, 1);
    `CHK("36 parallel", 72'hF, product)
    apb(0, DMS_STAT_OFF, 0);
    `CHK("stat src", 1'b1, rd[DMS_EV_SRC])
    @(posedge clk);
    source_a <= 0;
    $display("test shift done");
  endtask

  task automatic t_pipe;
    apb(1, DMS_CTRL_OFF, M18 | PP);
    drv(36'h6, 36'h5, 0, 0, 2);
    `CHK("pipe", 72'h1E, product)
    drv(36'h7, 36'h5, 0, 0, 1);
    `CHK("pipe old", 72'h1E, product)
    @(posedge clk);
    #1 `CHK("pipe new", 72'h23, product)
    apb(1, DMS_CTRL_OFF, SG | M18 | AR | (1 << DMS_CREG_BIT));
    drv(36'h3_FFFD, 36'h5, 1, 0, 2);
    `CHK("ctl reg", 36'hF_FFFF_FFF1, product[35:0])
    apb(0, DMS_PRLO_OFF, 0);
    `CHK("prod lo", 32'hFFFF_FFF1, rd)
    apb(0, DMS_PRHI_OFF, 0);
    `CHK("prod hi", 32'hFFFF_FFFF, rd)
    drv(36'h3_FFFD, 36'h5, 0, 0, 1);
    `CHK("ctl lag", 36'hF_FFFF_FFF1, product[35:0])
    @(posedge clk);
    #1 `CHK("ctl new", 36'h0_0013_FFF1, product[35:0])
    $display("test pipe done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_sign();
    t_frac();
    t_shift();
    t_pipe();
    print_verdict();
  end
endmodule // dms_mult_stage_test
